// File: hdl/front_panel_regs.svh
// Constants of the front-panel switch and button decoder
`ifndef FRONT_PANEL_REGS_SVH
`define FRONT_PANEL_REGS_SVH

// Clock rate and times
`define CLK_FREQ_KHZ     10000
`define HOLD_TIME_MS     3000
`define CONFIRM_TIME_MS  1000
`define DEBOUNCE_TIME_MS 20
`define CNT_W            26

// Switch positions, 1 means ON
`define SW_ADDR_LSB      0
`define SW_ADDR_MSB      3
`define SW_BAUD_LSB      4
`define SW_BAUD_MSB      5
`define SW_TERM          6
`define SW_SECURE        7

// Baud codes
`define BAUD_9600        2'h0
`define BAUD_19200       2'h1
`define BAUD_38400       2'h2
`define BAUD_57600       2'h3

// Reset values
`define DEFAULT_IP       32'hc0a80101
`define ADDR_RESET       6'h00

`endif

// File: hdl/front_panel_pkg.sv
// Types of the front-panel switch and button decoder
package front_panel_pkg;

   // Button sequencer states
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_HOLD    = 4'b0010,
      ST_CONFIRM = 4'b0100,
      ST_RELEASE = 4'b1000
   } panel_state_t;

   // Settings that switches or software choose
   typedef struct packed {
      logic [5:0] address;
      logic [1:0] baud_code;
      logic       termination;
      logic       download_enable;
   } link_cfg_t;

   // One-cycle factory reset requests
   typedef struct packed {
      logic config_reset;
      logic comm_reset;
      logic password_reset;
      logic netmgr_reset;
   } reset_req_t;

   // Debouncer state
   typedef struct packed {
      logic              level;
      logic [25:0]       count;
   } debounce_state_t;

   // Top-level state
   typedef struct packed {
      panel_state_t fsm;
      logic [1:0]   combo;
      logic [25:0]  count;
      logic         led_all_on;
      reset_req_t   req;
      link_cfg_t    cfg;
      logic         sw_control;
      logic         download_accept;
      logic         download_refuse;
      logic [31:0]  ip_address;
   } panel_t;

endpackage : front_panel_pkg

// File: hdl/button_debounce.sv
// Debouncer for one pushbutton
`timescale 1ns/10ps
`default_nettype none
`include "front_panel_regs.svh"

module button_debounce #(
   parameter int unsigned DEBOUNCE_CYCLES = 1
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic raw,
   output logic      level
);

   front_panel_pkg::debounce_state_t st;
   front_panel_pkg::debounce_state_t next_st;

   // Level follows the input only after it held steady for the debounce time
   always_comb begin
      next_st = st;
      if (raw == st.level) begin
         next_st.count = '0;
      end else if (st.count == `CNT_W'(DEBOUNCE_CYCLES - 1)) begin
         next_st.level = raw;
         next_st.count = '0;
      end else begin
         next_st.count = st.count + `CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;

   a_debounce_settle: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(st.level) |-> ($past(raw) == st.level)
         && ($past(st.count) == `CNT_W'(DEBOUNCE_CYCLES - 1)))
      else $error("Button level changed before the input settled");

endmodule : button_debounce
`default_nettype wire

// File: hdl/dip_decoder.sv
// Decoder of the configuration switch bank with software fallback
`timescale 1ns/10ps
`default_nettype none
`include "front_panel_regs.svh"

module dip_decoder (
   input  wire logic                     [7:0] dip_switch,
   input  wire front_panel_pkg::link_cfg_t     sw_cfg,
   output front_panel_pkg::link_cfg_t          cfg,
   output logic                                sw_control
);

   // All positions ON hands the address, baud, termination and download settings to software
   assign sw_control = &dip_switch;

   // Switch or software source for each setting
   always_comb begin
      if (sw_control) begin
         cfg = sw_cfg;
      end else begin
         cfg.address         = {2'h0, dip_switch[`SW_ADDR_MSB:`SW_ADDR_LSB]};
         cfg.baud_code       = dip_switch[`SW_BAUD_MSB:`SW_BAUD_LSB];
         cfg.termination     = dip_switch[`SW_TERM];
         cfg.download_enable = dip_switch[`SW_SECURE];
      end
   end

endmodule : dip_decoder
`default_nettype wire

// File: hdl/front_panel_switch_decoder.sv
// Front-panel button sequencer and configuration switch decoder
`timescale 1ns/10ps
`default_nettype none
`include "front_panel_regs.svh"

module front_panel_switch_decoder #(
   parameter int unsigned HOLD_CYCLES     = `HOLD_TIME_MS * `CLK_FREQ_KHZ,
   parameter int unsigned CONFIRM_CYCLES  = `CONFIRM_TIME_MS * `CLK_FREQ_KHZ,
   parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_TIME_MS * `CLK_FREQ_KHZ
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       config_reset_button,
   input  wire logic       comm_reset_button,
   input  wire logic [7:0] dip_switch,
   input  wire logic [5:0] sw_address,
   input  wire logic [1:0] sw_baud_code,
   input  wire logic       sw_termination,
   input  wire logic       sw_download_enable,
   input  wire logic       download_request,
   output logic            config_reset,
   output logic            comm_reset,
   output logic            password_reset,
   output logic            netmgr_reset,
   output logic            led_all_on,
   output logic [5:0]      device_address,
   output logic [1:0]      baud_code,
   output logic            termination_on,
   output logic            download_enable,
   output logic            sw_control_active,
   output logic            download_accept,
   output logic            download_refuse,
   output logic [31:0]     ip_address
);

   front_panel_pkg::panel_t    st;
   front_panel_pkg::panel_t    next_st;
   front_panel_pkg::link_cfg_t sw_cfg;
   front_panel_pkg::link_cfg_t dec_cfg;
   logic                       dec_sw_control;
   logic [1:0]                 raw_buttons;
   logic [1:0]                 pressed;

   // Bit 0 is the configuration button, bit 1 the communication button
   assign raw_buttons = {comm_reset_button, config_reset_button};

   // One debouncer per button
   generate
      for (genvar i = 0; i < 2; i++) begin : g_debounce
         button_debounce #(
            .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
         ) u_debounce (
            .clk     (clk),
            .reset_n (reset_n),
            .raw     (raw_buttons[i]),
            .level   (pressed[i])
         );
      end
   endgenerate

   // Software settings gathered for the decoder
   assign sw_cfg.address         = sw_address;
   assign sw_cfg.baud_code       = sw_baud_code;
   assign sw_cfg.termination     = sw_termination;
   assign sw_cfg.download_enable = sw_download_enable;

   // Switch bank decoding
   dip_decoder u_dip_decoder (
      .dip_switch (dip_switch),
      .sw_cfg     (sw_cfg),
      .cfg        (dec_cfg),
      .sw_control (dec_sw_control)
   );

   // Next state: button sequencing, reset requests and registered settings
   always_comb begin
      next_st                 = st;
      next_st.req             = '0;
      next_st.cfg             = dec_cfg;
      next_st.sw_control      = dec_sw_control;
      next_st.ip_address      = `DEFAULT_IP;
      next_st.download_accept = download_request && dec_cfg.download_enable;
      next_st.download_refuse = download_request && !dec_cfg.download_enable;
      case (st.fsm)
         front_panel_pkg::ST_IDLE: begin
            next_st.led_all_on = 1'b0;
            if (pressed != 2'h0) begin
               next_st.fsm   = front_panel_pkg::ST_HOLD;
               next_st.combo = pressed;
               next_st.count = '0;
            end
         end
         front_panel_pkg::ST_HOLD: begin
            if (pressed == 2'h0) begin
               // Released early: no reset at all
               next_st.fsm = front_panel_pkg::ST_IDLE;
            end else if (pressed != st.combo) begin
               // Combination changed: time the new one from zero
               next_st.combo = pressed;
               next_st.count = '0;
            end else if (st.count == `CNT_W'(HOLD_CYCLES - 1)) begin
               next_st.fsm        = front_panel_pkg::ST_CONFIRM;
               next_st.count      = '0;
               next_st.led_all_on = 1'b1;
               case (st.combo)
                  2'h1: next_st.req.config_reset = 1'b1;
                  2'h2: next_st.req.comm_reset   = 1'b1;
                  2'h3: begin
                     if (dip_switch[`SW_SECURE]) begin
                        next_st.req.netmgr_reset = 1'b1;
                     end else begin
                        next_st.req.password_reset = 1'b1;
                     end
                  end
                  default: next_st.fsm = front_panel_pkg::ST_IDLE;
               endcase
            end else begin
               next_st.count = st.count + `CNT_W'(1);
            end
         end
         front_panel_pkg::ST_CONFIRM: begin
            // All LEDs stay lit for the confirmation time
            if (st.count == `CNT_W'(CONFIRM_CYCLES - 1)) begin
               next_st.fsm        = front_panel_pkg::ST_RELEASE;
               next_st.count      = '0;
               next_st.led_all_on = 1'b0;
            end else begin
               next_st.count = st.count + `CNT_W'(1);
            end
         end
         front_panel_pkg::ST_RELEASE: begin
            // A held button never starts a second reset
            if (pressed == 2'h0) begin
               next_st.fsm = front_panel_pkg::ST_IDLE;
            end
         end
         default: begin
            next_st.fsm        = front_panel_pkg::ST_IDLE;
            next_st.count      = '0;
            next_st.led_all_on = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st                     <= '0;
         st.fsm                 <= front_panel_pkg::ST_IDLE;
         st.cfg.address         <= `ADDR_RESET;
         st.cfg.baud_code       <= `BAUD_9600;
         st.ip_address          <= `DEFAULT_IP;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign config_reset      = st.req.config_reset;
   assign comm_reset        = st.req.comm_reset;
   assign password_reset    = st.req.password_reset;
   assign netmgr_reset      = st.req.netmgr_reset;
   assign led_all_on        = st.led_all_on;
   assign device_address    = st.cfg.address;
   assign baud_code         = st.cfg.baud_code;
   assign termination_on    = st.cfg.termination;
   assign download_enable   = st.cfg.download_enable;
   assign sw_control_active = st.sw_control;
   assign download_accept   = st.download_accept;
   assign download_refuse   = st.download_refuse;
   assign ip_address        = st.ip_address;

   // A full hold: same combination for the whole hold time
   sequence s_hold_done;
      (st.fsm == front_panel_pkg::ST_HOLD) && (st.count == `CNT_W'(HOLD_CYCLES - 1))
         && (pressed == st.combo);
   endsequence

   sequence s_any_reset;
      st.req != 4'h0;
   endsequence

   a_cfg_reset_cause: assert property (@(posedge clk) disable iff (!reset_n)
      config_reset |-> $past(st.combo) == 2'h1 && $past(st.fsm) == front_panel_pkg::ST_HOLD
         && $past(st.count) == `CNT_W'(HOLD_CYCLES - 1))
      else $error("Configuration reset without a full first-button hold");

   a_comm_reset_cause: assert property (@(posedge clk) disable iff (!reset_n)
      s_hold_done ##0 (st.combo == 2'h2) |=> comm_reset && !config_reset)
      else $error("Second-button hold did not give a communication reset");

   a_password_reset: assert property (@(posedge clk) disable iff (!reset_n)
      s_hold_done ##0 (st.combo == 2'h3) ##0 !dip_switch[`SW_SECURE]
         |=> password_reset && !netmgr_reset)
      else $error("Two-button hold with switch 8 off did not reset passwords");

   a_netmgr_reset: assert property (@(posedge clk) disable iff (!reset_n)
      netmgr_reset |-> $past(dip_switch[`SW_SECURE]) && $past(st.combo) == 2'h3)
      else $error("Network manager reset without switch 8 on and both buttons");

   a_led_confirm: assert property (@(posedge clk) disable iff (!reset_n)
      s_any_reset |-> led_all_on [*4])
      else $error("LEDs did not confirm an accepted reset");

   a_reset_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
      s_any_reset |-> $onehot0(st.req) ##1 (st.req == 4'h0))
      else $error("More than one reset or a reset longer than one cycle");

   a_addr_decode: assert property (@(posedge clk) disable iff (!reset_n)
      !(&dip_switch) |=> device_address == {2'h0, $past(dip_switch[3:0])})
      else $error("Device address does not follow switches 1 to 4");

   a_baud_decode: assert property (@(posedge clk) disable iff (!reset_n)
      !(&dip_switch) |=> baud_code == $past(dip_switch[5:4]))
      else $error("Baud code does not follow switches 5 and 6");

   a_term_follow: assert property (@(posedge clk) disable iff (!reset_n)
      !(&dip_switch) |=> termination_on == $past(dip_switch[6]))
      else $error("Termination does not follow switch 7");

   a_download_gate: assert property (@(posedge clk) disable iff (!reset_n)
      download_request && !dip_switch[`SW_SECURE] |=> download_refuse && !download_accept)
      else $error("Download accepted with switch 8 off");

   a_software_path: assert property (@(posedge clk) disable iff (!reset_n)
      &dip_switch |=> sw_control_active && device_address == $past(sw_address)
         && download_enable == $past(sw_download_enable))
      else $error("Software settings not used with all switches on");

   a_default_ip: assert property (@(posedge clk) disable iff (!reset_n)
      ip_address == 32'hc0a80101)
      else $error("Default network address is wrong");

   a_early_release: assert property (@(posedge clk) disable iff (!reset_n)
      (st.fsm == front_panel_pkg::ST_HOLD) && (pressed == 2'h0) |=> (st.req == 4'h0)
         && st.fsm == front_panel_pkg::ST_IDLE)
      else $error("Early release did not abandon the hold");

   // Sequencer bookkeeping: last cycle of the confirmation window
   sequence s_confirm_end;
      (st.fsm == front_panel_pkg::ST_CONFIRM) && (st.count == `CNT_W'(CONFIRM_CYCLES - 1));
   endsequence

   a_fsm_onehot: assert property (@(posedge clk) disable iff (!reset_n)
      $onehot(st.fsm))
      else $error("Button sequencer state is not one-hot");

   a_hold_start: assert property (@(posedge clk) disable iff (!reset_n)
      (st.fsm == front_panel_pkg::ST_IDLE) && (pressed != 2'h0)
         |=> (st.fsm == front_panel_pkg::ST_HOLD) && (st.count == '0))
      else $error("A debounced press did not start a hold");

   a_hold_bound: assert property (@(posedge clk) disable iff (!reset_n)
      (st.fsm == front_panel_pkg::ST_HOLD) |-> (st.count <= `CNT_W'(HOLD_CYCLES - 1)))
      else $error("Hold counter ran past the threshold");

   a_combo_restart: assert property (@(posedge clk) disable iff (!reset_n)
      (st.fsm == front_panel_pkg::ST_HOLD) && (pressed != 2'h0) && (pressed != st.combo)
         |=> (st.count == '0) && (st.combo == $past(pressed)))
      else $error("A changed button combination did not restart the hold");

   a_release_wait: assert property (@(posedge clk) disable iff (!reset_n)
      (st.fsm == front_panel_pkg::ST_RELEASE) && (pressed != 2'h0)
         |=> (st.fsm == front_panel_pkg::ST_RELEASE) && (st.req == 4'h0))
      else $error("A button still held after a reset started another one");

   // Confirmation lamp checks
   a_confirm_end: assert property (@(posedge clk) disable iff (!reset_n)
      s_confirm_end |=> !led_all_on && (st.fsm == front_panel_pkg::ST_RELEASE))
      else $error("LEDs did not go dark after the confirmation time");

   a_led_fall: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(led_all_on) |-> ($past(st.fsm) == front_panel_pkg::ST_CONFIRM)
         && ($past(st.count) == `CNT_W'(CONFIRM_CYCLES - 1)))
      else $error("LEDs went dark before the confirmation time ended");

   a_led_rise: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(led_all_on) |-> s_any_reset)
      else $error("LEDs lit without an accepted reset");

   a_led_state: assert property (@(posedge clk) disable iff (!reset_n)
      led_all_on |-> (st.fsm == front_panel_pkg::ST_CONFIRM))
      else $error("LEDs lit outside the confirmation window");

   // Reset causes seen from the pulse side
   a_comm_cause: assert property (@(posedge clk) disable iff (!reset_n)
      comm_reset |-> ($past(st.combo) == 2'h2)
         && ($past(st.count) == `CNT_W'(HOLD_CYCLES - 1)))
      else $error("Communication reset without a full second-button hold");

   a_password_cause: assert property (@(posedge clk) disable iff (!reset_n)
      password_reset |-> !$past(dip_switch[`SW_SECURE]) && ($past(st.combo) == 2'h3))
      else $error("Password reset without switch 8 off and both buttons");

   // Download gating and settings source
   a_accept_gate: assert property (@(posedge clk) disable iff (!reset_n)
      download_request && dip_switch[`SW_SECURE] && !(&dip_switch)
         |=> download_accept && !download_refuse)
      else $error("Download refused with switch 8 on");

   a_download_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !download_request |=> !download_accept && !download_refuse)
      else $error("Download answer without a request");

   a_dl_follow: assert property (@(posedge clk) disable iff (!reset_n)
      !(&dip_switch) |=> download_enable == $past(dip_switch[`SW_SECURE]))
      else $error("Download enable does not follow switch 8");

   a_sw_control: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1 |=> sw_control_active == $past(&dip_switch))
      else $error("Software control flag does not follow the switch bank");

   a_software_link: assert property (@(posedge clk) disable iff (!reset_n)
      &dip_switch |=> (baud_code == $past(sw_baud_code))
         && (termination_on == $past(sw_termination)))
      else $error("Software baud or termination not used with all switches on");

endmodule : front_panel_switch_decoder
`default_nettype wire

// File: tb/operator_panel.sv
// Operator side model: two pushbuttons whose contacts chatter on each change
`timescale 1ns/10ps
`default_nettype none

module operator_panel #(
   parameter int BOUNCE = 2
) (
   input  wire logic       clk,
   input  wire logic [1:0] press,
   output logic      [1:0] raw
);
   int         left [2] = '{0, 0};
   logic [1:0] last = 2'h0;

   // Chatter for BOUNCE cycles after the hand moves, then settle on the pressed level
   always @(posedge clk) begin
      #20;
      for (int i = 0; i < 2; i++) begin
         if (press[i] !== last[i]) begin
            left[i] = BOUNCE;
         end
         last[i] = press[i];
         if (left[i] > 0) begin
            raw[i] = ~raw[i];
            left[i]--;
         end else begin
            raw[i] = press[i];
         end
      end
   end
endmodule : operator_panel

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the front-panel switch and button decoder
`timescale 1ns/10ps
`default_nettype none

module testbench;
   localparam int H = 50;
   localparam int C = 16;
   localparam int D = 4;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [1:0]  press = 2'h0;
   wire  [1:0]  raw;
   logic [7:0]  dip = 8'hff;
   logic [5:0]  sw_address = 6'h00;
   logic [1:0]  sw_baud_code = 2'h0;
   logic        sw_termination = 1'b0;
   logic        sw_download_enable = 1'b0;
   logic        download_request = 1'b0;
   logic        cfg_r, comm_r, pw_r, nm_r, led, term, dl_en, sw_ctl, acc, dl_refuse;
   logic [5:0]  addr;
   logic [1:0]  baud;
   logic [31:0] ip;
   wire  [3:0]  pulses = {cfg_r, comm_r, pw_r, nm_r};
   int          miscompares = 0;
   int          n_tests = 0;

   always #50 clk = ~clk;

   operator_panel i_panel (.clk(clk), .press(press), .raw(raw));

   front_panel_switch_decoder #(.HOLD_CYCLES(H), .CONFIRM_CYCLES(C), .DEBOUNCE_CYCLES(D)) i_dut (
      .clk(clk), .reset_n(reset_n), .config_reset_button(raw[0]), .comm_reset_button(raw[1]),
      .dip_switch(dip), .sw_address(sw_address), .sw_baud_code(sw_baud_code),
      .sw_termination(sw_termination), .sw_download_enable(sw_download_enable),
      .download_request(download_request), .config_reset(cfg_r), .comm_reset(comm_r),
      .password_reset(pw_r), .netmgr_reset(nm_r), .led_all_on(led), .device_address(addr),
      .baud_code(baud), .termination_on(term), .download_enable(dl_en),
      .sw_control_active(sw_ctl), .download_accept(acc), .download_refuse(dl_refuse),
      .ip_address(ip));

   // Closing report and verdict
   task automatic results();
      $display("counts: %0d compared, %0d mismatched", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // Wait n edges, then let their updates settle
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : step

   // Switch decode, or the software settings when every switch is ON
   function automatic logic [9:0] exp_cfg(input logic [7:0] d, input logic [9:0] s);
      if (d === 8'hff) begin
         return s;
      end
      return {2'h0, d[3:0], d[5:4], d[6], d[7]};
   endfunction : exp_cfg

   // Reset kind: {config, comm, password, network manager}
   function automatic logic [3:0] exp_kind(input logic [1:0] b, input logic d8);
      if (b == 2'b01) return 4'h8;
      if (b == 2'b10) return 4'h4;
      return d8 ? 4'h1 : 4'h2;
   endfunction : exp_kind

   // Apply switches and software settings, check decode and one download request
   task automatic settings(input logic [7:0] d);
      logic [9:0] e;
      dip = d;
      {sw_address, sw_baud_code, sw_termination, sw_download_enable} = 10'($urandom);
      e = exp_cfg(d, {sw_address, sw_baud_code, sw_termination, sw_download_enable});
      step(1);
      chk("settings", 32'(e), 32'({addr, baud, term, dl_en}));
      chk("sw control", 32'(d === 8'hff), 32'(sw_ctl));
      download_request = 1'b1;
      step(1);
      chk("download", 32'({e[0], ~e[0]}), 32'({acc, dl_refuse}));
      download_request = 1'b0;
      step(1);
      chk("download idle", 32'h0, 32'({acc, dl_refuse}));
   endtask : settings

   // Hold a combination until a reset fires, then watch the confirmation
   task automatic hold(input logic [1:0] b, input logic d8);
      int         t;
      int         lit;
      logic [3:0] seen;
      dip = {d8, 7'($urandom)};
      press = b;
      seen = 4'h0;
      for (t = 0; t < H + 40 && seen === 4'h0; t++) begin
         step(1);
         seen = pulses;
      end
      chk("reset kind", 32'(exp_kind(b, d8)), 32'(seen));
      chk("hold time", 32'h1, 32'(t >= H && t <= H + 30));
      chk("confirm led", 32'h1, 32'(led));
      lit = 0;
      while (led === 1'b1 && lit < C + 8) begin
         step(1);
         lit++;
         chk("repeat reset", 32'h0, 32'(pulses));
      end
      chk("led time", 32'h1, 32'(lit >= C - 1 && lit <= C + 1));
      press = 2'h0;
      step(D + 10);
      $display("hold test %b done", b);
      if (seen === 4'h0 || lit >= C + 8) begin
         results();
      end
   endtask : hold

   // Press then release before the threshold: nothing may fire
   task automatic short_press(input logic [1:0] b);
      logic [4:0] any;
      any = 5'h0;
      press = b;
      repeat (H - 10) begin
         step(1);
         any = any | {led, pulses};
      end
      press = 2'h0;
      repeat (H + 20) begin
         step(1);
         any = any | {led, pulses};
      end
      chk("early release", 32'h0, 32'(any));
      $display("short press test %b done", b);
   endtask : short_press

   initial begin
      void'($urandom(69502));
      repeat (16) @(posedge clk);
      #10;
      chk("reset ip", 32'hc0a80101, ip);
      chk("reset outputs", 32'h0, 32'({led, pulses, addr, baud, term, dl_en, sw_ctl}));
      reset_n = 1'b1;
      step(2);
      chk("ip", 32'hc0a80101, ip);
      settings(8'h00);
      settings(8'hff);
      settings(8'h7f);
      settings(8'hfe);
      settings(8'h30);
      for (int i = 0; i < 40; i++) begin
         settings((i % 5 == 0) ? 8'hff : 8'($urandom));
      end
      $display("settings test done");
      hold(2'b01, 1'b0);
      hold(2'b10, 1'b1);
      hold(2'b11, 1'b0);
      hold(2'b11, 1'b1);
      short_press(2'b01);
      short_press(2'b11);
      press = 2'b01;
      step(20);
      hold(2'b11, 1'b0);
      results();
   end
endmodule : testbench

`default_nettype wire
